// ### tb/dac_fault_power_control_test.sv
// self-checking bench for the dac power and fault control block
`timescale 1ns/1ns
module dac_fault_power_control_test
	import dac_pwr_pkg::*;
;
	logic sys_clk, rst_b, load_n, overtemp, sclk, fs_n, sdi, sdo, th_flag, ref_pwr;
	logic [3:0] oc, pwr, clamp, climit, oc_flag, upd;
	logic [63:0] code;
	logic [15:0] lfsr;
	logic [23:0] rd;
	int mismatches, total_checks, cycles;
	int upd_cnt[4];
	// reference model state
	logic [3:0] m_pwr, m_oc;
	logic m_ref, m_th;
	logic [15:0] m_code[4];
	int m_upd[4];

	dac_fault_power_control DUT (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .serial_clk_i(sclk),
		.frame_sync_n_i(fs_n), .serial_data_in_i(sdi), .load_outputs_n_i(load_n),
		.overcurrent_i(oc), .overtemp_i(overtemp), .serial_data_out_o(sdo),
		.channel_power_up_bit_o(pwr), .gnd_clamp_o(clamp), .current_limit_o(climit),
		.reference_power_up_bit_o(ref_pwr), .overcurrent_alert_flag_o(oc_flag),
		.thermal_alert_flag_o(th_flag), .dac_update_o(upd), .dac_code_o(code));
	serial_host_model host (.serial_data_out_i(sdo), .serial_clk_o(sclk),
		.frame_sync_n_o(fs_n), .serial_data_in_o(sdi));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// update pulse counting and hang guard
	always @(posedge sys_clk) begin
		cycles++;
		for (int c = 0; c < 4; c++) if (upd[c] === 1'b1) upd_cnt[c]++;
		if (cycles == 20000) begin
			mismatches++;
			final_report();
		end
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic cmp_state();
		check(pwr, m_pwr);
		check(clamp, {~m_pwr});
		check(ref_pwr, m_ref);
		check(oc_flag, m_oc);
		check(th_flag, m_th);
	endtask : cmp_state

	task automatic wr(input logic [2:0] sel, input logic [2:0] addr, input logic [15:0] d);
		host.xfer({2'b00, sel, addr, d}, 24, rd);
	endtask : wr

	// thermal flag, and overcurrent flags in auto mode, only clear on a power write once the fault has gone
	task automatic wr_pwr(input logic [15:0] d);
		wr(SEL_PWR, 3'h0, d);
		m_pwr = d[3:0];
		m_ref = d[4];
		m_oc = m_oc & oc;
		m_th = m_th & overtemp;
	endtask : wr_pwr

	// a read word loads the readback; the next frame shifts it out
	task automatic rdback(input logic [2:0] sel, input logic [15:0] exp);
		host.xfer({2'b10, sel, 3'h0, 16'h0000}, 24, rd);
		host.xfer({2'b10, 3'h1, 3'h0, 16'h0000}, 24, rd);
		check(rd, {2'b00, sel, 3'h0, exp});
	endtask : rdback

	task automatic waitc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : waitc

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rst_b = 1'b0;
		load_n = 1'b0;
		overtemp = 1'b0;
		oc = 4'h0;
		lfsr = 16'h0046;
		m_pwr = CH_PWR_RST;
		m_oc = 4'h0;
		m_ref = REF_PWR_RST;
		m_th = 1'b0;
		for (int c = 0; c < 4; c++) m_code[c] = 16'h0000;
		waitc(5);
		rst_b = 1'b1;
		#13;
		waitc(4);
		cmp_state();
		// status positions written as ones must not stick
		wr_pwr(16'h03FF);
		cmp_state();
		// load inside the settle window is ignored
		wr(SEL_DAC, 3'h3, 16'h1234);
		check(code[63:48], 16'h0000);
		rdback(SEL_PWR, 16'h001F);
		waitc(260);
		// automatic update with load held low, random codes
		for (int c = 0; c < 4; c++) begin
			lfsr = lfsr_next(lfsr);
			wr(SEL_DAC, c[2:0], lfsr);
			m_code[c] = lfsr;
			m_upd[c]++;
		end
		check(code, {m_code[3], m_code[2], m_code[1], m_code[0]});
		// held load: output waits for the falling edge
		load_n = 1'b1;
		wr(SEL_DAC, 3'h0, ~m_code[0]);
		check(code[15:0], m_code[0]);
		waitc(1);
		load_n = 1'b0;
		m_code[0] = ~m_code[0];
		// a load pulse reloads and flags every ready channel, changed or not
		for (int c = 0; c < 4; c++) m_upd[c]++;
		waitc(10);
		check(code, {m_code[3], m_code[2], m_code[1], m_code[0]});
		for (int c = 0; c < 4; c++) check(upd_cnt[c], m_upd[c]);
		// a frame cut short after 12 bits is dropped
		host.xfer({2'b00, SEL_PWR, 3'h0, 16'h0000}, 12, rd);
		cmp_state();
		// auto power-down, stays down after the fault goes
		waitc(1);
		oc = 4'h2;
		waitc(8);
		m_pwr[1] = 1'b0;
		m_oc[1] = 1'b1;
		cmp_state();
		oc = 4'h0;
		waitc(20);
		cmp_state();
		rdback(SEL_PWR, {6'h00, m_oc, m_th, m_ref, m_pwr});
		wr_pwr(16'h001F);
		cmp_state();
		// clamp mode: powered, flag follows the fault
		wr(SEL_CTRL, 3'h0, 16'h0004);
		oc = 4'h4;
		waitc(8);
		m_oc = 4'h4;
		cmp_state();
		check(climit, 4'h4);
		oc = 4'h0;
		waitc(8);
		m_oc = 4'h0;
		cmp_state();
		check(climit, 4'h0);
		// overtemp ignored until shutdown is enabled
		overtemp = 1'b1;
		waitc(8);
		cmp_state();
		overtemp = 1'b0;
		wr(SEL_CTRL, 3'h0, 16'h000C);
		overtemp = 1'b1;
		waitc(8);
		m_pwr = 4'h0;
		m_th = 1'b1;
		cmp_state();
		rdback(SEL_PWR, {6'h00, m_oc, m_th, m_ref, m_pwr});
		overtemp = 1'b0;
		waitc(8);
		wr_pwr(16'h000F);
		cmp_state();
		final_report();
	end
endmodule : dac_fault_power_control_test

// ### tb/serial_host_model.sv
// host side serial master model for the three-wire link
`timescale 1ns/1ns
module serial_host_model
	import dac_pwr_pkg::*;
#(
	parameter bit EXT_REF = 1'b0
) (
	input wire logic serial_data_out_i,
	output logic serial_clk_o,
	output logic frame_sync_n_o,
	output logic serial_data_in_o
);
	// ------------------------------------------------------------
	// idle link: clock stands low, frame sync high
	// ------------------------------------------------------------
	initial begin
		serial_clk_o = 1'b0;
		frame_sync_n_o = 1'b1;
		serial_data_in_o = 1'b1;
	end

	// one frame of n bits, msb first; readback sampled on falling edges
	task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] rd);
		rd = 24'h000000;
		if (EXT_REF && w[21:19] == SEL_PWR) begin
			w[PWR_REF_BIT] = 1'b0;
		end
		// a 7 ns lead keeps the link edges off the system clock edges
		#7 frame_sync_n_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			serial_data_in_o = w[23 - i];
			#40 serial_clk_o = 1'b1;
			#80 serial_clk_o = 1'b0;
			rd = {rd[22:0], serial_data_out_i};
			#40;
		end
		frame_sync_n_o = 1'b1;
		// released line shows the inverse so a stale level is never trusted
		serial_data_in_o = ~serial_data_in_o;
		#793;
	endtask : xfer
endmodule : serial_host_model

// ### verilog/dac_fault_power_control.sv
// power, fault and serial link logic of the quad dac
// Contract
// - clamp off: overcurrent powers channel down, grounds it
// - auto mode sets alert flag, clears power bit
// - thermal shutdown only while enable bit set
// - overtemp when enabled: all channels off, flag set
// - reference off at reset, on only by bit
// - exactly 24 bits per frame, sampled falling
// - link is clock, data and frame sync
// - update outputs on full word or load pulse
// - host reads registers back including status bits
// - clamp on: stays powered, flag follows fault
// - power bits reset zero; wait 10 us before load
// - thermal and overcurrent alert bits are read-only
`timescale 1ns/1ns
module dac_fault_power_control
	import dac_pwr_pkg::*;
#(
	parameter int CH = 4,
	parameter int DW = 16
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic serial_clk_i,
	input wire logic frame_sync_n_i,
	input wire logic serial_data_in_i,
	input wire logic load_outputs_n_i,
	input wire logic [3:0] overcurrent_i,
	input wire logic overtemp_i,
	output logic serial_data_out_o,
	output logic [3:0] channel_power_up_bit_o,
	output logic [3:0] gnd_clamp_o,
	output logic [3:0] current_limit_o,
	output logic reference_power_up_bit_o,
	output logic [3:0] overcurrent_alert_flag_o,
	output logic thermal_alert_flag_o,
	output logic [3:0] dac_update_o,
	output logic [63:0] dac_code_o
);
	if (CH != 4 || DW != 16) $error("only four 16-bit channels are supported");
	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rst_q1_ff, rst_n;
	// release through two flops; assertion stays asynchronous
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_q1_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1_ff <= 1'b1;
			rst_n <= rst_q1_ff;
		end
	end
	// ------------------------------------------------------------
	// link domain: shift in on falling edge, shift out on rising
	// ------------------------------------------------------------
	logic [4:0] lcnt_ff, nxt_lcnt;
	logic [22:0] lshift_ff, nxt_lshift;
	frame_s lword_ff, nxt_lword;
	logic ltgl_ff, nxt_ltgl, sdo_ff;
	frame_s rb_ff, nxt_rb;
	// bits past the 24th are ignored; a short frame never completes
	always_comb begin
		nxt_lcnt = lcnt_ff;
		nxt_lshift = lshift_ff;
		nxt_lword = lword_ff;
		nxt_ltgl = ltgl_ff;
		if (lcnt_ff != CNT_DONE) begin
			nxt_lcnt = 5'(lcnt_ff + 5'h01);
			nxt_lshift = {lshift_ff[21:0], serial_data_in_i};
		end
		if (lcnt_ff == LAST_BIT) begin
			nxt_lword = {lshift_ff, serial_data_in_i};
			nxt_ltgl = ~ltgl_ff;
		end
	end
	// frame sync high clears the count, so a stopped clock between frames is harmless
	always_ff @(negedge serial_clk_i or negedge rst_n or posedge frame_sync_n_i) begin
		if (!rst_n) begin
			lcnt_ff <= CNT_RST;
		end else if (frame_sync_n_i) begin
			lcnt_ff <= CNT_RST;
		end else begin
			lcnt_ff <= nxt_lcnt;
		end
	end
	always_ff @(negedge serial_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			lshift_ff <= 23'h000000;
			lword_ff <= FRAME_RST;
			ltgl_ff <= 1'b0;
		end else begin
			lshift_ff <= nxt_lshift;
			lword_ff <= nxt_lword;
			ltgl_ff <= nxt_ltgl;
		end
	end
	// readback word is quasi-static: written in the sys domain a frame earlier
	always_ff @(posedge serial_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sdo_ff <= 1'b0;
		end else if (lcnt_ff < CNT_DONE) begin
			sdo_ff <= rb_ff[5'(LAST_BIT - lcnt_ff)];
		end else begin
			sdo_ff <= 1'b0;
		end
	end
	assign serial_data_out_o = sdo_ff;
	// ------------------------------------------------------------
	// pin synchronisers: three flops, change taken when 2nd and 3rd agree
	// ------------------------------------------------------------
	logic [6:0] pin_raw, s1_ff, s2_ff, s3_ff, filt_ff, nxt_filt;
	logic [3:0] ovc_f;
	logic ot_f, load_f, tgl_f;
	assign pin_raw = {ltgl_ff, load_outputs_n_i, overtemp_i, overcurrent_i};
	assign {tgl_f, load_f, ot_f, ovc_f} = filt_ff;
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++) begin : g_pin
			always_comb begin
				nxt_filt[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : filt_ff[gi];
			end
			always_ff @(posedge sys_clk_i or negedge rst_n) begin
				if (!rst_n) begin
					s1_ff[gi] <= PIN_RST[gi];
					s2_ff[gi] <= PIN_RST[gi];
					s3_ff[gi] <= PIN_RST[gi];
					filt_ff[gi] <= PIN_RST[gi];
				end else begin
					s1_ff[gi] <= pin_raw[gi];
					s2_ff[gi] <= s1_ff[gi];
					s3_ff[gi] <= s2_ff[gi];
					filt_ff[gi] <= nxt_filt[gi];
				end
			end
		end
	endgenerate
	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	logic tgl_seen_ff, load_q_ff, word_evt, wr_pwr, wr_ctrl, wr_dac, load_evt;
	assign word_evt = tgl_f != tgl_seen_ff;
	assign wr_pwr = word_evt && !lword_ff.rd && lword_ff.sel == SEL_PWR;
	assign wr_ctrl = word_evt && !lword_ff.rd && lword_ff.sel == SEL_CTRL;
	assign wr_dac = word_evt && !lword_ff.rd && lword_ff.sel == SEL_DAC;
	assign load_evt = load_q_ff && !load_f;
	// ------------------------------------------------------------
	// power and fault state
	// ------------------------------------------------------------
	logic [3:0] pwr_ff, nxt_pwr, ovc_flag_ff, nxt_ovc_flag, gclamp_ff, ilim_ff;
	logic ref_ff, nxt_ref, therm_ff, nxt_therm, oten_ff, nxt_oten, clamp_ff, nxt_clamp;
	logic [8:0] settle_ff [4], nxt_settle [4];
	logic [3:0] ready;
	always_comb begin
		nxt_pwr = pwr_ff;
		nxt_ref = ref_ff;
		nxt_oten = oten_ff;
		nxt_clamp = clamp_ff;
		nxt_ovc_flag = ovc_flag_ff;
		nxt_therm = therm_ff;
		if (wr_ctrl) begin
			nxt_oten = lword_ff.data[CTRL_OTEN_BIT];
			nxt_clamp = lword_ff.data[CTRL_CLAMP_BIT];
		end
		// status positions of the written word are dropped
		if (wr_pwr) begin
			nxt_pwr = lword_ff.data[PWR_CH_LSB +: 4];
			nxt_ref = lword_ff.data[PWR_REF_BIT];
			nxt_ovc_flag = ovc_flag_ff & ovc_f;
			nxt_therm = therm_ff & ot_f;
		end
		// faults win over a write in the same cycle
		if (clamp_ff) begin
			nxt_ovc_flag = ovc_f;
		end else begin
			nxt_pwr = nxt_pwr & ~ovc_f;
			nxt_ovc_flag = nxt_ovc_flag | ovc_f;
		end
		if (oten_ff && ot_f) begin
			nxt_pwr = CH_PWR_RST;
			nxt_therm = 1'b1;
		end
	end
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pwr_ff <= CH_PWR_RST;
			gclamp_ff <= GND_CLAMP_RST;
			ilim_ff <= 4'h0;
			ref_ff <= REF_PWR_RST;
			oten_ff <= OTEN_RST;
			clamp_ff <= CLAMP_RST;
			ovc_flag_ff <= 4'h0;
			therm_ff <= 1'b0;
		end else begin
			pwr_ff <= nxt_pwr;
			gclamp_ff <= ~nxt_pwr;
			ilim_ff <= clamp_ff ? ovc_f : 4'h0;
			ref_ff <= nxt_ref;
			oten_ff <= nxt_oten;
			clamp_ff <= nxt_clamp;
			ovc_flag_ff <= nxt_ovc_flag;
			therm_ff <= nxt_therm;
		end
	end
	// ------------------------------------------------------------
	// dac registers, settle timers and output update
	// ------------------------------------------------------------
	logic [15:0] dac_in_ff [4], dac_out_ff [4], nxt_in [4], nxt_out [4];
	logic [3:0] upd_ff, nxt_upd;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ch
			assign ready[gi] = pwr_ff[gi] && settle_ff[gi] == SETTLE_ZERO;
			// a freshly powered channel refuses loads until its amplifier settles
			always_comb begin
				nxt_settle[gi] = settle_ff[gi];
				nxt_in[gi] = dac_in_ff[gi];
				nxt_out[gi] = dac_out_ff[gi];
				nxt_upd[gi] = 1'b0;
				if (nxt_pwr[gi] && !pwr_ff[gi]) begin
					nxt_settle[gi] = SETTLE_CNT;
				end else if (settle_ff[gi] != SETTLE_ZERO) begin
					nxt_settle[gi] = 9'(settle_ff[gi] - 9'h001);
				end
				if (wr_dac && lword_ff.addr == 3'(gi)) begin
					nxt_in[gi] = lword_ff.data;
				end
				if (ready[gi] && (load_evt || (wr_dac && !load_f && lword_ff.addr == 3'(gi)))) begin
					nxt_out[gi] = load_evt ? dac_in_ff[gi] : lword_ff.data;
					nxt_upd[gi] = 1'b1;
				end
			end
			always_ff @(posedge sys_clk_i or negedge rst_n) begin
				if (!rst_n) begin
					settle_ff[gi] <= SETTLE_ZERO;
					dac_in_ff[gi] <= 16'h0000;
					dac_out_ff[gi] <= 16'h0000;
					upd_ff[gi] <= 1'b0;
				end else begin
					settle_ff[gi] <= nxt_settle[gi];
					dac_in_ff[gi] <= nxt_in[gi];
					dac_out_ff[gi] <= nxt_out[gi];
					upd_ff[gi] <= nxt_upd[gi];
				end
			end
			assign dac_code_o[gi*16 +: 16] = dac_out_ff[gi];
		end
	endgenerate
	// ------------------------------------------------------------
	// readback word and event bookkeeping
	// ------------------------------------------------------------
	always_comb begin
		nxt_rb = rb_ff;
		if (word_evt && lword_ff.rd) begin
			nxt_rb = lword_ff;
			nxt_rb.rd = 1'b0;
			nxt_rb.data = 16'h0000;
			if (lword_ff.sel == SEL_PWR) begin
				nxt_rb.data[PWR_CH_LSB +: 4] = pwr_ff;
				nxt_rb.data[PWR_REF_BIT] = ref_ff;
				nxt_rb.data[PWR_THERM_BIT] = therm_ff;
				nxt_rb.data[PWR_OVC_LSB +: 4] = ovc_flag_ff;
			end else if (lword_ff.sel == SEL_CTRL) begin
				nxt_rb.data[CTRL_CLAMP_BIT] = clamp_ff;
				nxt_rb.data[CTRL_OTEN_BIT] = oten_ff;
			end else if (lword_ff.sel == SEL_DAC) begin
				nxt_rb.data = dac_in_ff[lword_ff.addr[1:0]];
			end
		end
	end
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rb_ff <= FRAME_RST;
			tgl_seen_ff <= 1'b0;
			load_q_ff <= 1'b1;
		end else begin
			rb_ff <= nxt_rb;
			tgl_seen_ff <= tgl_f;
			load_q_ff <= load_f;
		end
	end
	assign channel_power_up_bit_o = pwr_ff;
	assign gnd_clamp_o = gclamp_ff;
	assign current_limit_o = ilim_ff;
	assign reference_power_up_bit_o = ref_ff;
	assign overcurrent_alert_flag_o = ovc_flag_ff;
	assign thermal_alert_flag_o = therm_ff;
	assign dac_update_o = upd_ff;
	// ------------------------------------------------------------
	// assertions and covers
	// ------------------------------------------------------------
	a_auto_power_down: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(!clamp_ff && ovc_f != 4'h0) |=> ((pwr_ff & $past(ovc_f)) == 4'h0
		&& (gclamp_ff & $past(ovc_f)) == $past(ovc_f)))
		else $error("faulted channel not powered down");
	a_alert_flag_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(!clamp_ff && ovc_f != 4'h0) |=> ((ovc_flag_ff & $past(ovc_f)) == $past(ovc_f)))
		else $error("overcurrent flag not set");
	a_no_self_restore: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(!wr_pwr && pwr_ff != 4'hF) |=> ((pwr_ff & ~$past(pwr_ff)) == 4'h0))
		else $error("channel restored without host write");
	a_thermal_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		$rose(therm_ff) |-> $past(oten_ff && ot_f))
		else $error("thermal flag without enable");
	a_thermal_shut: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(oten_ff && ot_f) |=> (pwr_ff == 4'h0 && therm_ff && gclamp_ff == 4'hF))
		else $error("thermal shutdown incomplete");
	a_ref_by_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		$rose(ref_ff) |-> $past(wr_pwr && lword_ff.data[PWR_REF_BIT]))
		else $error("reference powered without write");
	a_frame_length: assert property (@(negedge serial_clk_i) disable iff (!rst_n)
		$changed(ltgl_ff) |-> $past(lcnt_ff) == LAST_BIT)
		else $error("word completed at wrong bit count");
	a_auto_update: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(wr_dac && !load_f && !load_evt && ready[lword_ff.addr[1:0]] && !lword_ff.addr[2])
		|=> dac_update_o[$past(lword_ff.addr[1:0])])
		else $error("complete word did not update output");
	a_clamp_follow: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(clamp_ff && $past(clamp_ff)) |-> overcurrent_alert_flag_o == $past(ovc_f))
		else $error("clamp flag does not follow fault");
	a_settle_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		$rose(pwr_ff[0]) |-> (!ready[0]) [*8])
		else $error("load allowed before settling");
	a_status_ro: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		$rose(ovc_flag_ff[0]) |-> $past(ovc_f[0]))
		else $error("alert flag set by write");
	c_auto_pd: cover property (@(posedge sys_clk_i) disable iff (!rst_n)
		!clamp_ff && pwr_ff[0] && ovc_f[0]);
	c_thermal: cover property (@(posedge sys_clk_i) disable iff (!rst_n) $rose(therm_ff));
	c_readback: cover property (@(posedge sys_clk_i) disable iff (!rst_n)
		word_evt && lword_ff.rd);
	c_load_pulse: cover property (@(posedge sys_clk_i) disable iff (!rst_n)
		load_evt && ready != 4'h0);
endmodule : dac_fault_power_control

// ### verilog/dac_pwr_pkg.sv
// constants, field layouts and carrier types for the dac power and fault control block
package dac_pwr_pkg;
	// ------------------------------------------------------------
	// link framing
	// ------------------------------------------------------------
	localparam int FRAME_BITS = 24;
	localparam logic [4:0] LAST_BIT = 5'h17;
	localparam logic [4:0] CNT_RST = 5'h00;
	localparam logic [4:0] CNT_DONE = 5'h18;
	// ------------------------------------------------------------
	// register select codes and power control fields
	// ------------------------------------------------------------
	localparam logic [2:0] SEL_DAC = 3'h0;
	localparam logic [2:0] SEL_PWR = 3'h2;
	localparam logic [2:0] SEL_CTRL = 3'h3;
	localparam int PWR_CH_LSB = 0;
	localparam int PWR_REF_BIT = 4;
	localparam int PWR_THERM_BIT = 5;
	localparam int PWR_OVC_LSB = 6;
	localparam int CTRL_CLAMP_BIT = 2;
	localparam int CTRL_OTEN_BIT = 3;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [3:0] CH_PWR_RST = 4'h0;
	localparam logic [3:0] GND_CLAMP_RST = 4'hF;
	localparam logic REF_PWR_RST = 1'b0;
	localparam logic OTEN_RST = 1'b0;
	localparam logic CLAMP_RST = 1'b0;
	localparam logic [6:0] PIN_RST = 7'h20;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 40;
	localparam int SETTLE_NS = 10000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [8:0] SETTLE_CNT = 9'(SETTLE_CYC);
	localparam logic [8:0] SETTLE_ZERO = 9'h000;
	// ------------------------------------------------------------
	// serial word carrier
	// ------------------------------------------------------------
	typedef struct packed {
		logic rd;
		logic rsv;
		logic [2:0] sel;
		logic [2:0] addr;
		logic [15:0] data;
	} frame_s;
	localparam frame_s FRAME_RST = 24'h000000;
endpackage : dac_pwr_pkg
